// *** core/otp_program_strobe_n_device.sv ***
// device end: programming port of the one-time-programmable array
`timescale 1ns/100ps
// What this block does
// (R1) sample algorithm select after reset, programming level
// (R2) port 3 carries programming word bits 7:0
// (R3) port 4 carries programming word bits 15:8
// (R4) programming bus is open-drain and bidirectional
// (R5) auto mode runs bus as system bus
// (R6) slave mode uses open-drain port, programmer pulls up
// (R7) command latch low captures command or address
// (R8) program strobe honoured only in slave mode
// (R9) strobe rise latches and starts, fall ends
// (R10) verify high means word programmed correctly in slave mode; in auto mode it rises when the pulse count ends, with no compare
// (R11) activity output low while auto programming runs
// (R12) outside programming ports are open-drain byte ports
// (R13) software keeps port 2 bit 6 an output
// (R14) select decoding through a parameterised table
module otp_program_strobe_n_device
    import otp_program_strobe_n_pkg::*;
#(
    parameter logic [SEL_W-1:0] SEL_SLAVE = SEL_SLAVE_DEF, // slave select code
    parameter logic [SEL_W-1:0] SEL_AUTO  = SEL_AUTO_DEF   // auto select code
) (
    input  wire logic         CLOCK,          // system clock
    input  wire logic         RST_N,          // async reset, active low
    otp_program_strobe_n_if.device        PINS,           // programming pins
    input  wire logic [7:0]   PORT3_WRITE,    // port 3 output latch, normal mode
    input  wire logic [7:0]   PORT4_WRITE,    // port 4 output latch, normal mode
    output logic      [7:0]   PORT3_READ,     // port 3 pin state
    output logic      [7:0]   PORT4_READ,     // port 4 pin state
    output logic      [1:0]   MODE,           // decoded programming mode
    output logic              AUTO_DONE       // auto programming finished
);
    // -------------------------------------------------------------
    // mode capture
    // -------------------------------------------------------------
    logic              sampled;
    program_strobe_n_mode_e        mode;
    logic [WORD_W-1:0] programming_word_bus_in;
    logic [WORD_W-1:0] bus_out;
    logic [WORD_W-1:0] bus_oe;

    function automatic program_strobe_n_mode_e decode_sel(input logic [SEL_W-1:0] s);
        if (s == SEL_SLAVE) begin
            return MODE_SLAVE;
        end else if (s == SEL_AUTO) begin
            return MODE_AUTO;
        end
        return MODE_NONE;
    endfunction : decode_sel

    wire program_strobe_n_level = ~PINS.external_access_n;
    assign programming_word_bus_in = PINS.programming_word_bus; // R2 R3

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sampled <= 1'b0;
            mode    <= MODE_NONE;
        end else if (!sampled) begin
            sampled <= 1'b1; // R1
            mode    <= program_strobe_n_level ? decode_sel(PINS.programming_algorithm_select) : MODE_NONE; // R14
        end
    end

    wire is_slave = (mode == MODE_SLAVE);
    wire is_auto  = (mode == MODE_AUTO);

    // -------------------------------------------------------------
    // array storage
    // -------------------------------------------------------------
    logic [WORD_W-1:0] mem [MEM_DEPTH];
    logic [MEM_DEPTH-1:0] written;

    // -------------------------------------------------------------
    // slave command path
    // -------------------------------------------------------------
    cmd_state_e        cmd_state;
    logic [BYTE_W-1:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic              strobe_d;
    logic              burning;
    logic [WORD_W-1:0] burn_data;
    logic [7:0]        burn_cnt;
    logic              verify;
    logic              dumping;

    wire latch_act   = is_slave & ~PINS.program_command_latch_n; // R7
    wire strobe_hi   = is_slave & PINS.program_strobe_n; // R8
    wire strobe_rise = strobe_hi & ~strobe_d; // R9
    wire strobe_fall = ~strobe_hi & strobe_d; // R9
    wire [MEM_AW-1:0] waddr = addr[MEM_AW-1:0];

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_state <= CMD_IDLE;
            cmd       <= 8'h00;
            addr      <= 16'h0000;
        end else if (latch_act && cmd_state != CMD_WAIT_ADDR) begin
            cmd       <= programming_word_bus_in[BYTE_W-1:0]; // R7
            cmd_state <= CMD_WAIT_ADDR;
        end else if (latch_act) begin
            addr      <= programming_word_bus_in; // R7
            cmd_state <= CMD_READY;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            strobe_d <= 1'b0;
        end else begin
            strobe_d <= strobe_hi;
        end
    end

    // -------------------------------------------------------------
    // auto programming sequencer
    // -------------------------------------------------------------
    auto_state_e       ap_state;
    logic [7:0]        ap_idx;
    logic              ap_rd;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ap_state <= AP_IDLE;
            ap_idx   <= 8'h00;
            ap_rd    <= 1'b0;
        end else begin
            case (ap_state)
                AP_IDLE: begin
                    if (sampled && is_auto) begin
                        ap_state <= AP_ADDR;
                    end
                end
                AP_ADDR: begin
                    ap_rd    <= 1'b1; // R5
                    ap_state <= AP_READ;
                end
                AP_READ: begin
                    ap_rd    <= 1'b0; // R5
                    ap_state <= AP_BURN;
                end
                AP_BURN: begin
                    if (burn_cnt == 8'h00 && !burning) begin
                        ap_idx   <= ap_idx + 8'h01;
                        ap_state <= (ap_idx == AUTO_WORDS - 8'h01) ? AP_DONE : AP_ADDR;
                    end
                end
                default: ap_state <= AP_DONE;
            endcase
        end
    end

    wire ap_start = (ap_state == AP_READ);

    // -------------------------------------------------------------
    // programming pulse and verify
    // -------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            burning   <= 1'b0;
            burn_data <= 16'h0000;
            burn_cnt  <= 8'h00;
            verify    <= 1'b0;
            dumping   <= 1'b0;
        end else if (strobe_rise && cmd_state == CMD_READY && cmd == CMD_PROGRAM) begin
            burning   <= 1'b1; // R9
            burn_data <= programming_word_bus_in;
            verify    <= 1'b0; // R10
            dumping   <= 1'b0;
        end else if (strobe_rise && cmd_state == CMD_READY && cmd == CMD_DUMP) begin
            dumping   <= 1'b1; // R6
        end else if (strobe_fall) begin
            burning   <= 1'b0; // R9
            dumping   <= 1'b0;
            verify    <= burning & (mem[waddr] == burn_data); // R10
        end else if (ap_start) begin
            burning   <= 1'b1;
            burn_data <= programming_word_bus_in; // R5
            burn_cnt  <= PROGRAM_STROBE_N_PULSE_CYC;
            verify    <= 1'b0;
        end else if (is_auto && burn_cnt != 8'h00) begin
            burn_cnt  <= burn_cnt - 8'h01;
            burning   <= (burn_cnt != 8'h01);
            verify    <= (burn_cnt == 8'h01); // R10
        end
    end

    // otp cells only clear bits once; written words are and-ed
    wire [MEM_AW-1:0] burn_addr = is_auto ? ap_idx : waddr;
    always_ff @(posedge CLOCK) begin
        if (burning) begin
            mem[burn_addr] <= (written[burn_addr] ? mem[burn_addr] : '1) & burn_data;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            written <= '0;
        end else if (burning) begin
            written[burn_addr] <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // pin drive
    // -------------------------------------------------------------
    wire [WORD_W-1:0] dump_word = mem[waddr];
    wire [WORD_W-1:0] normal_w  = {PORT4_WRITE, PORT3_WRITE};

    always_comb begin
        if (is_auto) begin
            bus_out = {8'h00, ap_idx}; // R5
            bus_oe  = (ap_state == AP_ADDR) ? '1 : '0;
        end else if (is_slave) begin
            bus_out = dump_word; // R4 R6
            bus_oe  = dumping ? ~dump_word : '0;
        end else begin
            bus_out = normal_w; // R12
            bus_oe  = ~normal_w;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            PINS.bus_dev_out          <= '1;
            PINS.bus_dev_oe           <= '0;
            PINS.program_verify_ok    <= 1'b0;
            PINS.programming_active_n <= 1'b1;
            PINS.sys_rd_n             <= 1'b1;
            PORT3_READ                <= 8'h00;
            PORT4_READ                <= 8'h00;
            MODE                      <= 2'h0;
            AUTO_DONE                 <= 1'b0;
        end else begin
            PINS.bus_dev_out          <= bus_out; // R4
            PINS.bus_dev_oe           <= bus_oe;
            PINS.program_verify_ok    <= verify; // R10
            PINS.programming_active_n <= ~(is_auto && ap_state != AP_IDLE
                                           && ap_state != AP_DONE); // R11
            PINS.sys_rd_n             <= ~ap_rd; // R5
            PORT3_READ                <= programming_word_bus_in[LOW_LSB +: BYTE_W]; // R2
            PORT4_READ                <= programming_word_bus_in[HIGH_LSB +: BYTE_W]; // R3
            MODE                      <= mode;
            AUTO_DONE                 <= (ap_state == AP_DONE);
        end
    end
endmodule : otp_program_strobe_n_device

// *** pkg/otp_program_strobe_n_pkg.sv ***
// constants and types shared by both ends of the programming port
package otp_program_strobe_n_pkg;
    // -------------------------------------------------------------
    // bus layout
    // -------------------------------------------------------------
    localparam int WORD_W  = 16;
    localparam int BYTE_W  = 8;
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 8;
    localparam int SEL_W   = 4;
    localparam int ADDR_W  = 16;
    localparam int MEM_DEPTH = 256;
    localparam int MEM_AW    = 8;

    // -------------------------------------------------------------
    // algorithm select encodings (default table)
    // -------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_SLAVE_DEF = 4'hC;
    localparam logic [SEL_W-1:0] SEL_AUTO_DEF  = 4'h5;

    // -------------------------------------------------------------
    // slave command codes (low byte of a latched command word)
    // -------------------------------------------------------------
    localparam logic [BYTE_W-1:0] CMD_PROGRAM = 8'h01;
    localparam logic [BYTE_W-1:0] CMD_DUMP    = 8'h02;

    // -------------------------------------------------------------
    // timing counts
    // -------------------------------------------------------------
    localparam logic [7:0] PROGRAM_STROBE_N_PULSE_CYC = 8'h04;
    localparam logic [7:0] AUTO_WORDS     = 8'h10;
    localparam logic [7:0] VERIFY_LAG_CYC = 8'h02;

    typedef enum logic [1:0] {MODE_NONE, MODE_SLAVE, MODE_AUTO} program_strobe_n_mode_e;
    typedef enum logic [1:0] {CMD_IDLE, CMD_WAIT_ADDR, CMD_READY} cmd_state_e;
    typedef enum logic [2:0] {AP_IDLE, AP_ADDR, AP_READ, AP_BURN, AP_DONE} auto_state_e;
endpackage : otp_program_strobe_n_pkg

// *** pkg/otp_program_strobe_n_if.sv ***
// pin-level interface between the device and the programmer
`timescale 1ns/100ps
interface otp_program_strobe_n_if;
    import otp_program_strobe_n_pkg::*;
    logic [WORD_W-1:0] bus_dev_out;
    logic [WORD_W-1:0] bus_dev_oe;
    logic [WORD_W-1:0] bus_prg_out;
    logic [WORD_W-1:0] bus_prg_oe;
    logic              program_command_latch_n;
    logic              program_strobe_n;
    logic              program_verify_ok;
    logic              programming_active_n;
    logic [SEL_W-1:0]  programming_algorithm_select;
    logic              external_access_n;
    logic              sys_rd_n;
    wire  [WORD_W-1:0] programming_word_bus;

    // open drain with pull-ups: low if anyone drives low
    genvar i;
    for (i = 0; i < WORD_W; i++) begin : g_wire
        assign programming_word_bus[i] =
            ~((bus_dev_oe[i] & ~bus_dev_out[i]) | (bus_prg_oe[i] & ~bus_prg_out[i]));
    end

    modport device (
        input  programming_word_bus, program_command_latch_n, program_strobe_n,
        input  programming_algorithm_select, external_access_n,
        output bus_dev_out, bus_dev_oe, program_verify_ok, programming_active_n, sys_rd_n
    );
    modport programmer (
        input  programming_word_bus, program_verify_ok, programming_active_n, sys_rd_n,
        output bus_prg_out, bus_prg_oe, program_command_latch_n, program_strobe_n,
        output programming_algorithm_select, external_access_n
    );
endinterface : otp_program_strobe_n_if

// *** core/otp_programmer.sv ***
// programmer end: drives select, command latch and strobe
`timescale 1ns/100ps
module otp_programmer
    import otp_program_strobe_n_pkg::*;
(
    input  wire logic              CLOCK,      // system clock
    input  wire logic              RST_N,      // async reset, active low
    otp_program_strobe_n_if.programmer         PINS,       // programming pins
    input  wire logic [SEL_W-1:0]  SEL,        // algorithm select to present
    input  wire logic              START,      // pulse: program one word
    input  wire logic              DUMP,       // pulse: read one word
    input  wire logic [ADDR_W-1:0] ADDR,       // target address
    input  wire logic [WORD_W-1:0] DATA,       // word to program
    output logic                   BUSY,       // sequence in progress
    output logic                   OK,         // last word verified
    output logic [WORD_W-1:0]      RDATA       // dumped word
);
    typedef enum logic [2:0] {P_IDLE, P_CMD, P_ADDR, P_DATA, P_RISE, P_HOLD, P_FALL} prg_e;
    prg_e              st;
    logic              dump_op;
    logic [7:0]        cnt;

    // unregistered, so the device sees the wanted code at its first edge after reset
    assign PINS.programming_algorithm_select = SEL; // R1

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st  <= P_IDLE;
            dump_op <= 1'b0;
            cnt <= 8'h00;
            PINS.bus_prg_out <= '1;
            PINS.bus_prg_oe  <= '0;
            PINS.program_command_latch_n <= 1'b1;
            PINS.program_strobe_n <= 1'b0;
            PINS.external_access_n <= 1'b0;
            BUSY  <= 1'b0;
            OK    <= 1'b0;
            RDATA <= 16'h0000;
        end else begin
            case (st)
                P_IDLE: begin
                    BUSY <= 1'b0;
                    if (START || DUMP) begin
                        dump_op <= DUMP;
                        BUSY <= 1'b1;
                        st <= P_CMD;
                    end
                end
                P_CMD: begin
                    PINS.bus_prg_out <= {8'h00, dump_op ? CMD_DUMP : CMD_PROGRAM};
                    PINS.bus_prg_oe  <= '1;
                    PINS.program_command_latch_n <= 1'b0; // R7
                    st <= P_ADDR;
                end
                P_ADDR: begin
                    PINS.bus_prg_out <= ADDR; // R7
                    st <= P_DATA;
                end
                P_DATA: begin
                    PINS.program_command_latch_n <= 1'b1;
                    PINS.bus_prg_out <= DATA;
                    PINS.bus_prg_oe  <= dump_op ? '0 : '1; // R6
                    st <= P_RISE;
                end
                P_RISE: begin
                    PINS.program_strobe_n <= 1'b1; // R9
                    cnt <= PROGRAM_STROBE_N_PULSE_CYC;
                    st <= P_HOLD;
                end
                P_HOLD: begin
                    if (cnt == 8'h01) begin
                        RDATA <= PINS.programming_word_bus;
                        PINS.program_strobe_n <= 1'b0; // R9
                        // the device result reaches the pin two edges after the fall
                        cnt <= VERIFY_LAG_CYC; // R10
                        st <= P_FALL;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: begin
                    PINS.bus_prg_oe <= '0;
                    if (cnt == 8'h00) begin
                        OK <= PINS.program_verify_ok; // R10
                        st <= P_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
            endcase
        end
    end
endmodule : otp_programmer

// *** dv/otp_program_strobe_n_asserts.sv ***
// concurrent checks on the programming pins between the two ends
`timescale 1ns/100ps
module otp_program_strobe_n_asserts
    import otp_program_strobe_n_pkg::*;
(
    input wire logic              CLOCK,                        // system clock
    input wire logic              RST_N,                        // async reset, active low
    input wire logic [WORD_W-1:0] bus_dev_oe,                   // device bus enables
    input wire logic              program_command_latch_n,      // command latch
    input wire logic              program_strobe_n,             // programming strobe
    input wire logic              program_verify_ok,            // verify result
    input wire logic              programming_active_n,         // auto activity
    input wire logic [SEL_W-1:0]  programming_algorithm_select, // algorithm select
    input wire logic              sys_rd_n                      // external memory read
);
    logic             first;
    logic [SEL_W-1:0] sel_q;
    wire  [SEL_W-1:0] sel_now  = first ? programming_algorithm_select : sel_q;
    wire              is_slave = (sel_now == SEL_SLAVE_DEF);
    wire              is_auto  = (sel_now == SEL_AUTO_DEF);

    // --------------------------------------------------------------
    // select as the device sees it after reset
    // --------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (first) begin
            sel_q <= programming_algorithm_select;
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    property p_sel_stable;
        !first |-> $stable(programming_algorithm_select);
    endproperty
    property p_none_no_verify;
        !is_slave && !is_auto |-> !program_verify_ok;
    endproperty
    property p_active_auto;
        !programming_active_n |-> is_auto;
    endproperty
    property p_rd_auto;
        !sys_rd_n |-> is_auto && !programming_active_n;
    endproperty
    property p_rd_pulse;
        $fell(sys_rd_n) |=> sys_rd_n;
    endproperty
    property p_latch_release;
        is_slave && !program_command_latch_n |-> bus_dev_oe == '0;
    endproperty
    property p_latch_strobe;
        !program_command_latch_n |-> $stable(program_strobe_n);
    endproperty
    property p_strobe_width;
        $rose(program_strobe_n) |-> program_strobe_n [*4] ##[1:2] !program_strobe_n;
    endproperty
    property p_verify_after_fall;
        is_slave && $rose(program_verify_ok) |->
            !program_strobe_n && ($past(program_strobe_n) == 1'b0);
    endproperty

    a_sel_stable: assert property (p_sel_stable)
        else $error("algorithm select changed while running");
    a_none_no_verify: assert property (p_none_no_verify)
        else $error("verify raised outside programming");
    a_active_auto: assert property (p_active_auto)
        else $error("activity output low outside auto mode");
    a_rd_auto: assert property (p_rd_auto)
        else $error("memory read outside auto activity");
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("memory read longer than one cycle");
    a_latch_release: assert property (p_latch_release)
        else $error("device drives bus during command latch");
    a_latch_strobe: assert property (p_latch_strobe)
        else $error("strobe moved during command latch");
    a_strobe_width: assert property (p_strobe_width)
        else $error("programming pulse width wrong");
    a_verify_after_fall: assert property (p_verify_after_fall)
        else $error("verify rose too early after strobe fall");

    c_slave_pulse: cover property ($rose(program_strobe_n) && is_slave);
    c_none_pulse: cover property ($rose(program_strobe_n) && !is_slave && !is_auto);
    c_verify: cover property ($rose(program_verify_ok));
    c_auto_read: cover property ($fell(sys_rd_n));
endmodule : otp_program_strobe_n_asserts

// *** dv/otprom_programming_port_tb.sv ***
// self-checking bench: programmer and device joined by the pin interface
`timescale 1ns/100ps
module otprom_programming_port_tb;
    import otp_program_strobe_n_pkg::*;
    typedef struct packed {
        logic [1:0]        kind;
        logic [WORD_W-1:0] word;
    } exp_s;
    logic              clock;
    logic              rst_n;
    logic [SEL_W-1:0]  sel;
    logic              start;
    logic              dump;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
    logic [7:0]        p3_wr;
    logic [7:0]        p4_wr;
    logic [7:0]        p3_rd;
    logic [7:0]        p4_rd;
    logic [1:0]        mode;
    logic              auto_done;
    logic              busy;
    logic              ok;
    logic [WORD_W-1:0] rdata;
    int                bad_count;
    int                checks;
    int                rd_falls;
    int                act_seen;
    int                seed;
    exp_s              exp_q[$];
    logic [WORD_W-1:0] words[8];
    logic [ADDR_W-1:0] addrs[8];

    otp_program_strobe_n_if pins ();
    otp_program_strobe_n_device #(.SEL_SLAVE(SEL_SLAVE_DEF), .SEL_AUTO(SEL_AUTO_DEF)) otp_program_strobe_n_device_i (
        .CLOCK(clock), .RST_N(rst_n), .PINS(pins), .PORT3_WRITE(p3_wr), .PORT4_WRITE(p4_wr),
        .PORT3_READ(p3_rd), .PORT4_READ(p4_rd), .MODE(mode), .AUTO_DONE(auto_done));
    otp_programmer otp_programmer_i (
        .CLOCK(clock), .RST_N(rst_n), .PINS(pins), .SEL(sel), .START(start), .DUMP(dump),
        .ADDR(addr), .DATA(data), .BUSY(busy), .OK(ok), .RDATA(rdata));
    otp_program_strobe_n_asserts otp_program_strobe_n_asserts_i (
        .CLOCK(clock), .RST_N(rst_n), .bus_dev_oe(pins.bus_dev_oe),
        .program_command_latch_n(pins.program_command_latch_n),
        .program_strobe_n(pins.program_strobe_n), .program_verify_ok(pins.program_verify_ok),
        .programming_active_n(pins.programming_active_n),
        .programming_algorithm_select(pins.programming_algorithm_select),
        .sys_rd_n(pins.sys_rd_n));

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic check_val(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] expv);
        checks++;
        if (seen !== expv) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check_val

    task automatic summarize();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic do_reset(input logic [SEL_W-1:0] s);
        @(negedge clock);
        rst_n = 1'b0;
        sel   = s;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
    endtask : do_reset

    task automatic wait_q(input int limit);
        int n;
        n = 0;
        while ((busy !== 1'b0 || exp_q.size() > 0) && n < limit) begin
            @(negedge clock);
            n++;
        end
        if (n >= limit) begin
            bad_count++;
        end
    endtask : wait_q

    task automatic run_op(input logic d, input logic [ADDR_W-1:0] a,
                          input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] expv);
        exp_q.push_back({1'b0, d, expv});
        start = ~d;
        dump  = d;
        addr  = a;
        data  = w;
        @(negedge clock);
        start = 1'b0;
        dump  = 1'b0;
        wait_q(200);
    endtask : run_op

    // --------------------------------------------------------------
    // result watcher and stimulus
    // --------------------------------------------------------------
    always @(negedge pins.sys_rd_n) if (rst_n === 1'b1) rd_falls++;
    always @(negedge pins.programming_active_n) if (rst_n === 1'b1) act_seen = 1;

    always @(negedge busy or posedge auto_done) begin
        exp_s e;
        if (rst_n === 1'b1 && exp_q.size() > 0) begin
            @(negedge clock);
            e = exp_q.pop_front();
            if (e.kind == 2'd0) begin
                check_val(16'(ok), e.word);
            end else if (e.kind == 2'd1) begin
                check_val(rdata, e.word);
            end else begin
                check_val(16'(rd_falls), e.word);
                check_val(16'(act_seen), 16'h0001);
            end
        end
    end

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        #2_000_000;
        bad_count++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        sel = SEL_SLAVE_DEF;
        start = 1'b0;
        dump = 1'b0;
        addr = 16'h0000;
        data = 16'h0000;
        p3_wr = 8'hFF;
        p4_wr = 8'hFF;
        bad_count = 0;
        checks = 0;
        rd_falls = 0;
        act_seen = 0;
        seed = $urandom(6764);
        do_reset(SEL_SLAVE_DEF);
        check_val(16'(mode), 16'(MODE_SLAVE));
        for (int i = 0; i < 8; i++) begin
            addrs[i] = {8'($urandom), 4'(i), 4'($urandom)};
            words[i] = 16'($urandom);
            run_op(1'b0, addrs[i], words[i], 16'h0001);
        end
        for (int i = 0; i < 8; i++) begin
            run_op(1'b1, addrs[i], 16'($urandom), words[i]);
        end
        // no programming mode: plain open-drain byte ports, strobe ignored
        do_reset(4'h0);
        check_val(16'(mode), 16'(MODE_NONE));
        p3_wr = 8'($urandom);
        p4_wr = 8'($urandom);
        repeat (3) @(negedge clock);
        check_val({p4_rd, p3_rd}, {p4_wr, p3_wr});
        check_val(16'(pins.programming_word_bus[7:0]), 16'(p3_wr));
        check_val(16'(pins.programming_word_bus[15:8]), 16'(p4_wr));
        p3_wr = 8'hFF;
        p4_wr = 8'hFF;
        @(negedge clock);
        run_op(1'b0, addrs[0], words[1], 16'h0000);
        // auto programming from external memory
        rd_falls = 0;
        do_reset(SEL_AUTO_DEF);
        check_val(16'(mode), 16'(MODE_AUTO));
        exp_q.push_back({2'd2, 8'h00, AUTO_WORDS});
        wait_q(3000);
        summarize();
    end
endmodule : otprom_programming_port_tb
